// [hdl/ild_exec.sv]
// Purpose: Opcode decode and result arithmetic
// Assumes: Operands stable for the whole cycle
// Notes:   Purely combinational, no state
`timescale 1ns/100ps
`include "ild_params.svh"
module ild_exec (
	ild_exec_if.exec bus
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic all_zero(input logic [7:0] v);
		return (v == 8'h00);
	endfunction

	function automatic logic match(input logic [13:0] i, input logic [13:0] m, input logic [13:0] p);
		return ((i & m) == p);
	endfunction

	// ------------------------------------------------------------------------
	// Decode and compute
	// ------------------------------------------------------------------------
	always_comb begin
		logic [7:0] lit;
		lit           = bus.instr[`ILD_LIT_MSB:`ILD_LIT_LSB];
		bus.op        = ild_pkg::ILD_OP_NONE;
		bus.result    = 8'h00;
		bus.dest_file = bus.instr[`ILD_DEST_BIT];
		if (match(bus.instr, `ILD_FILE_OP_MASK, `ILD_INC_PAT)) begin
			bus.op     = ild_pkg::ILD_OP_INCREMENT_FILE_REG;
			bus.result = bus.fdata + 8'h01;
		end else if (match(bus.instr, `ILD_FILE_OP_MASK, `ILD_INC_SKIP_PAT)) begin
			bus.op     = ild_pkg::ILD_OP_INCREMENT_SKIP_ON_ZERO;
			bus.result = bus.fdata + 8'h01;
		end else if (match(bus.instr, `ILD_OR_LIT_MASK, `ILD_OR_LIT_PAT)) begin
			bus.op     = ild_pkg::ILD_OP_OR_LITERAL_INTO_ACCUMULATOR;
			bus.result = bus.acc | lit;
		end else if (match(bus.instr, `ILD_LOAD_LIT_MASK, `ILD_LOAD_LIT_PAT)) begin
			bus.op     = ild_pkg::ILD_OP_LOAD_LITERAL_ACCUMULATOR;
			bus.result = lit;
		end
		bus.zero = all_zero(bus.result);
	end

endmodule // ild_exec

// [hdl/ild_exec_if.sv]
// Purpose: Carrier between the decoder core and the execute unit
// Assumes: One clock, combinational path through the execute unit
// Notes:   Modport exec for the unit, core for the top module
`timescale 1ns/100ps
interface ild_exec_if;
	logic [13:0]      instr;
	logic [7:0]       acc;
	logic [7:0]       fdata;
	ild_pkg::ild_op_t op;
	logic [7:0]       result;
	logic             zero;
	logic             dest_file;

	modport exec (input instr, acc, fdata, output op, result, zero, dest_file);
	modport core (output instr, acc, fdata, input op, result, zero, dest_file);
endinterface

// [hdl/ild_params.svh]
// Purpose: Constants of the increment and literal instruction decoder
// Assumes: 14-bit instruction words, 8-bit data
// Notes:   Included by bare name
`ifndef ILD_PARAMS_SVH
`define ILD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------------
`define ILD_FILE_OP_MASK   14'h3f00
`define ILD_INC_PAT        14'h0a00
`define ILD_INC_SKIP_PAT   14'h0f00
`define ILD_OR_LIT_MASK    14'h3f00
`define ILD_OR_LIT_PAT     14'h3800
`define ILD_LOAD_LIT_MASK  14'h3c00
`define ILD_LOAD_LIT_PAT   14'h3000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ILD_DEST_BIT       7
`define ILD_ADDR_MSB       6
`define ILD_ADDR_LSB       0
`define ILD_LIT_MSB        7
`define ILD_LIT_LSB        0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ILD_ACC_RST        8'h00
`define ILD_ZERO_RST       1'b0

`endif

// [hdl/ild_pkg.sv]
// Purpose: Types of the increment and literal instruction decoder
// Assumes: Nothing beyond the constants header
// Notes:   Types only
package ild_pkg;

	// ------------------------------------------------------------------------
	// Decoded operations
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		ILD_OP_NONE,
		ILD_OP_INCREMENT_FILE_REG,
		ILD_OP_INCREMENT_SKIP_ON_ZERO,
		ILD_OP_OR_LITERAL_INTO_ACCUMULATOR,
		ILD_OP_LOAD_LITERAL_ACCUMULATOR
	} ild_op_t;

	// ------------------------------------------------------------------------
	// Whole state of the top module
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic       zero;
		logic       skip;
		logic       file_we;
		logic [6:0] file_addr;
		logic [7:0] file_wdata;
		logic       done;
		logic       discard;
		logic       foreign;
	} ild_state_t;

endpackage

// [hdl/ild_top.sv]
// Purpose: Decode and execute four single-word instructions of an 8-bit core
// Assumes: Operand of the addressed file register arrives with the instruction
// Notes:   Owns the accumulator and the zero flag; file writes go out registered
`timescale 1ns/100ps
`include "ild_params.svh"
module ild_top #(
	parameter int DATA_W  = 8,
	parameter int ADDR_W  = 7,
	parameter int INSTR_W = 14
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               instr_valid,
	input  wire logic [INSTR_W-1:0] instr,
	input  wire logic [DATA_W-1:0]  file_rdata,
	output logic      [DATA_W-1:0]  acc,
	output logic                    zero_flag,
	output logic                    file_we,
	output logic      [ADDR_W-1:0]  file_addr,
	output logic      [DATA_W-1:0]  file_wdata,
	output logic                    done,
	output logic                    discard,
	output logic                    foreign
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	// Port widths and header fields must agree
	if (DATA_W != 8) begin : g_bad_data_w
		$error("ild_top serves only 8-bit data");
	end
	if (ADDR_W != 7) begin : g_bad_addr_w
		$error("ild_top serves only 7-bit file addresses");
	end
	if (INSTR_W != 14) begin : g_bad_instr_w
		$error("ild_top serves only 14-bit instruction words");
	end
	if (`ILD_ADDR_MSB - `ILD_ADDR_LSB + 1 != ADDR_W) begin : g_bad_addr_field
		$error("address field width differs from ADDR_W");
	end
	if (`ILD_LIT_MSB - `ILD_LIT_LSB + 1 != DATA_W) begin : g_bad_lit_field
		$error("literal field width differs from DATA_W");
	end
	if (`ILD_DEST_BIT <= `ILD_ADDR_MSB || `ILD_DEST_BIT >= INSTR_W) begin : g_bad_dest_bit
		$error("destination bit lies outside its slot");
	end
	// Each opcode pattern must lie inside its own mask
	if ((`ILD_INC_PAT & `ILD_FILE_OP_MASK) != `ILD_INC_PAT) begin : g_bad_inc_pat
		$error("increment pattern outside its mask");
	end
	if ((`ILD_INC_SKIP_PAT & `ILD_FILE_OP_MASK) != `ILD_INC_SKIP_PAT) begin : g_bad_skip_pat
		$error("increment-and-skip pattern outside its mask");
	end
	if ((`ILD_OR_LIT_PAT & `ILD_OR_LIT_MASK) != `ILD_OR_LIT_PAT) begin : g_bad_or_pat
		$error("literal OR pattern outside its mask");
	end
	if ((`ILD_LOAD_LIT_PAT & `ILD_LOAD_LIT_MASK) != `ILD_LOAD_LIT_PAT) begin : g_bad_load_pat
		$error("literal load pattern outside its mask");
	end
	// Both increments share one mask, so their patterns must differ
	if (`ILD_INC_PAT == `ILD_INC_SKIP_PAT) begin : g_same_inc_pat
		$error("increment patterns collide");
	end

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	ild_pkg::ild_state_t state_q;
	ild_pkg::ild_state_t state_d;

	ild_exec_if xbus ();

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Quiet copy: pulses low, everything else held
	function automatic ild_pkg::ild_state_t hold_state(input ild_pkg::ild_state_t s);
		ild_pkg::ild_state_t h;
		h         = s;
		h.file_we = 1'b0;
		h.done    = 1'b0;
		h.discard = 1'b0;
		h.foreign = 1'b0;
		return h;
	endfunction

	// State after a synchronous reset
	function automatic ild_pkg::ild_state_t reset_state();
		ild_pkg::ild_state_t r;
		r      = '0;
		r.acc  = `ILD_ACC_RST;
		r.zero = `ILD_ZERO_RST;
		return r;
	endfunction

	// Increment result to the accumulator or back into the file register
	function automatic ild_pkg::ild_state_t put_result(
		input ild_pkg::ild_state_t s,
		input logic                to_file,
		input logic [6:0]          addr,
		input logic [7:0]          result
	);
		ild_pkg::ild_state_t n;
		n = s;
		if (to_file) begin
			n.file_we    = 1'b1;
			n.file_addr  = addr;
			n.file_wdata = result;
		end else begin
			n.acc = result;
		end
		return n;
	endfunction

	// A registered write that the data path has not committed yet
	function automatic logic forward_hit(
		input logic       pend_we,
		input logic [6:0] pend_addr,
		input logic [6:0] addr
	);
		return pend_we && (pend_addr == addr);
	endfunction

	// ------------------------------------------------------------------------
	// Execute unit
	// ------------------------------------------------------------------------
	ild_exec u_exec (
		.bus (xbus.exec)
	);

	// ------------------------------------------------------------------------
	// Operand forwarding
	// ------------------------------------------------------------------------
	// The data path commits a registered file write one edge late, so a
	// back-to-back access to the same register would see the stale value.
	logic [6:0] cur_addr;
	logic       fwd_hit;

	always_comb begin
		cur_addr   = instr[`ILD_ADDR_MSB:`ILD_ADDR_LSB];
		fwd_hit    = forward_hit(state_q.file_we, state_q.file_addr, cur_addr);
		xbus.instr = instr;
		xbus.acc   = state_q.acc;
		xbus.fdata = fwd_hit ? state_q.file_wdata : file_rdata;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_d = hold_state(state_q);
		if (!rst_n) begin
			state_d = reset_state();
		end else if (instr_valid && state_q.skip) begin
			// Prefetched word is dropped; this slot is a no-operation
			// A pending skip waits through idle cycles for the next valid word
			state_d.skip    = 1'b0;
			state_d.discard = 1'b1;
			state_d.done    = 1'b1;
		end else if (instr_valid) begin
			case (xbus.op)
				ild_pkg::ILD_OP_INCREMENT_FILE_REG: begin
					state_d      = put_result(state_d, xbus.dest_file, cur_addr, xbus.result);
					state_d.zero = xbus.zero;
					state_d.done = 1'b1;
				end
				ild_pkg::ILD_OP_INCREMENT_SKIP_ON_ZERO: begin
					// Zero flag is not touched here
					state_d      = put_result(state_d, xbus.dest_file, cur_addr, xbus.result);
					state_d.skip = xbus.zero;
					state_d.done = !xbus.zero;
				end
				ild_pkg::ILD_OP_OR_LITERAL_INTO_ACCUMULATOR: begin
					state_d.acc  = xbus.result;
					state_d.zero = xbus.zero;
					state_d.done = 1'b1;
				end
				ild_pkg::ILD_OP_LOAD_LITERAL_ACCUMULATOR: begin
					state_d.acc  = xbus.result;
					state_d.done = 1'b1;
				end
				default: begin
					// Left to the rest of the core
					state_d.foreign = 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		state_q <= state_d;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	always_comb begin
		// Straight from the state flops, no logic after them
		acc        = state_q.acc;
		zero_flag  = state_q.zero;
		file_we    = state_q.file_we;
		file_addr  = state_q.file_addr;
		file_wdata = state_q.file_wdata;
		done       = state_q.done;
		discard    = state_q.discard;
		foreign    = state_q.foreign;
	end

endmodule // ild_top

// [test/ild_bench.sv]
// Purpose: Self-checking bench of ild_top
// Assumes: Inputs change on the falling edge
// Notes:   File registers preset in the model
`timescale 1ns/100ps
module ild_bench;
	logic        mclk        = 1'b0;
	logic        rst_n       = 1'b0;
	logic        instr_valid = 1'b0;
	logic [13:0] instr       = 14'h0000;
	logic [7:0]  file_rdata, acc, file_wdata;
	logic        zero_flag, file_we, done, discard, foreign;
	logic [6:0]  file_addr;
	int          fails    = 0;
	int          n_checks = 0;
	int          cycles   = 0;

	ild_top uut (.mclk, .rst_n, .instr_valid, .instr, .file_rdata, .acc, .zero_flag, .file_we, .file_addr,
		.file_wdata, .done, .discard, .foreign);
	ild_file_model fm (.mclk, .rd_addr(instr[6:0]), .file_we, .file_addr, .file_wdata, .file_rdata);

	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails = fails + 1;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask
	task automatic put(input logic [13:0] w);
		instr_valid = 1'b1;
		instr = w;
		@(negedge mclk);
	endtask
	task automatic idle(input string nm);
		instr_valid = 1'b0;
		@(negedge mclk);
		$display("test %s finished", nm);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic t_or();
		put(14'h309a);
		put(14'h3835);
		chk("or acc", 8'hbf, acc);
		chk("or zero", 8'h00, zero_flag);
		put(14'h3000);
		put(14'h3800);
		chk("or zero acc", 8'h00, acc);
		chk("or zero set", 8'h01, zero_flag);
		idle("or_literal");
	endtask
	task automatic t_load();
		for (int j = 0; j < 4; j++) begin
			put({4'hc, 2'(j), 8'h5a + 8'(j)});
			chk("load acc", 8'h5a + 8'(j), acc);
			chk("load zero", 8'h01, zero_flag);
			chk("load done", 8'h01, done);
		end
		idle("load_literal");
	endtask
	task automatic t_skip();
		put(14'h3801);
		chk("or zero clear", 8'h00, zero_flag);
		fm.mem[9] = 8'hff;
		put(14'h0f09);
		chk("skip acc", 8'h00, acc);
		chk("skip zero", 8'h00, zero_flag);
		chk("skip done", 8'h00, done);
		instr_valid = 1'b0;
		@(negedge mclk);
		put(14'h3077);
		chk("drop flag", 8'h01, discard);
		chk("drop acc", 8'h00, acc);
		fm.mem[9] = 8'h10;
		put(14'h0f89);
		chk("noskip data", 8'h11, file_wdata);
		chk("noskip done", 8'h01, done);
		put(14'h3077);
		chk("next acc", 8'h77, acc);
		chk("next drop", 8'h00, discard);
		idle("skip_on_zero");
	endtask
	task automatic t_inc();
		fm.mem[5] = 8'hff;
		put(14'h0a85);
		chk("inc we", 8'h01, file_we);
		chk("inc addr", 8'h05, {1'b0, file_addr});
		chk("inc data", 8'h00, file_wdata);
		chk("inc zero", 8'h01, zero_flag);
		put(14'h0a05);
		chk("fwd acc", 8'h01, acc);
		chk("fwd zero", 8'h00, zero_flag);
		chk("fwd we", 8'h00, file_we);
		put(14'h0b05);
		chk("other acc", 8'h01, acc);
		chk("other flag", 8'h01, foreign);
		idle("increment");
	endtask
	task automatic t_reset();
		fm.mem[3] = 8'hff;
		put(14'h0a03);
		put(14'h3055);
		put(14'h0f83);
		chk("pend zero", 8'h01, zero_flag);
		chk("pend done", 8'h00, done);
		rst_n       = 1'b0;
		instr_valid = 1'b0;
		@(negedge mclk);
		chk("rst acc", 8'h00, acc);
		chk("rst zero", 8'h00, zero_flag);
		rst_n = 1'b1;
		@(negedge mclk);
		put(14'h3042);
		chk("rst skip clear acc", 8'h42, acc);
		chk("rst skip clear drop", 8'h00, discard);
		idle("mid_reset");
	endtask

	initial begin
		repeat (5) @(negedge mclk);
		chk("reset acc", 8'h00, acc);
		rst_n = 1'b1;
		@(negedge mclk);
		t_or();
		t_load();
		t_skip();
		t_inc();
		t_reset();
		give_verdict();
	end
endmodule // ild_bench

// [test/ild_file_model.sv]
// Purpose: File register side of the data path
// Assumes: A write lands on the edge after file_we is seen
// Notes:   Read follows the instruction address at once
`timescale 1ns/100ps
module ild_file_model (
	input  wire logic       mclk,
	input  wire logic [6:0] rd_addr,
	input  wire logic       file_we,
	input  wire logic [6:0] file_addr,
	input  wire logic [7:0] file_wdata,
	output logic      [7:0] file_rdata
);
	logic [7:0] mem [128];
	assign file_rdata = mem[rd_addr];
	always @(posedge mclk) begin
		if (file_we)
			mem[file_addr] <= file_wdata;
	end
endmodule // ild_file_model

// [test/ild_top_properties.sv]
// Purpose: Port timing checks of ild_top
// Assumes: Default widths of the top module
// Notes:   Bound to every ild_top
`timescale 1ns/100ps
module ild_top_properties (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [13:0] instr,
	input wire logic [7:0]  file_rdata,
	input wire logic [7:0]  acc,
	input wire logic        zero_flag,
	input wire logic        file_we,
	input wire logic [6:0]  file_addr,
	input wire logic [7:0]  file_wdata,
	input wire logic        done,
	input wire logic        discard,
	input wire logic        foreign
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Forwarded operand, pending discard
	logic [7:0] opnd;
	logic       pend_q;
	logic       take;
	logic [5:0] op;
	assign opnd = (file_we && file_addr == instr[6:0]) ? file_wdata : file_rdata;
	assign take = instr_valid && !pend_q;
	assign op   = instr[13:8];
	always_ff @(posedge mclk) begin
		if (!rst_n)
			pend_q <= 1'b0;
		else if (instr_valid)
			pend_q <= take && op == 6'h0f && opnd == 8'hff;
	end
	inc_to_acc_a: assert property (take && op == 6'h0a && !instr[7] |=> acc == $past(opnd) + 8'h01
		&& zero_flag == (acc == 8'h00) && done && !file_we) else $error("increment into acc wrong");
	inc_to_file_a: assert property (take && op == 6'h0a && instr[7] |=> file_we
		&& file_addr == $past(instr[6:0]) && file_wdata == $past(opnd) + 8'h01) else $error("file write wrong");
	skip_keeps_flag_a: assert property (take && op == 6'h0f |=> $stable(zero_flag))
		else $error("skip changed zero flag");
	skip_drops_next_a: assert property (pend_q && instr_valid |=> discard && done && $stable(acc) && !file_we)
		else $error("skipped word not dropped");
	skip_cycles_a: assert property (take && op == 6'h0f |=> done == ($past(opnd) != 8'hff) && !discard)
		else $error("skip cycle count wrong");
	or_literal_a: assert property (take && op == 6'h38 |=> acc == ($past(acc) | $past(instr[7:0]))
		&& zero_flag == (acc == 8'h00) && done) else $error("literal or wrong");
	load_literal_a: assert property (take && instr[13:10] == 4'hc |=> acc == $past(instr[7:0])
		&& $stable(zero_flag) && done) else $error("literal load wrong");
	zero_on_inc_a: assert property (take && op == 6'h0a && instr[7] |=> zero_flag == (file_wdata == 8'h00))
		else $error("zero flag wrong");
endmodule // ild_top_properties

bind ild_top ild_top_properties u_props (.mclk, .rst_n, .instr_valid, .instr, .file_rdata, .acc, .zero_flag,
	.file_we, .file_addr, .file_wdata, .done, .discard, .foreign);
